// ### rtl/iab_pkg.sv
// Package for the integer add, logic and branch execution block
package iab_pkg;
    // Primary and extended opcodes
    localparam logic [5:0] OPC_ADDIC = 6'h0c;
    localparam logic [5:0] OPC_ADDIC_REC = 6'h0d;
    localparam logic [5:0] OPC_ADDI = 6'h0e;
    localparam logic [5:0] OPC_ADDIS = 6'h0f;
    localparam logic [5:0] OPC_BRANCH = 6'h12;
    localparam logic [5:0] OPC_ANDI = 6'h1c;
    localparam logic [5:0] OPC_ANDIS = 6'h1d;
    localparam logic [5:0] OPC_EXT = 6'h1f;
    localparam logic [8:0] XO_ADD = 9'h10a;
    localparam logic [8:0] XO_ADDC = 9'h00a;
    localparam logic [8:0] XO_ADDE = 9'h08a;
    localparam logic [8:0] XO_ADDME = 9'h0ea;
    localparam logic [8:0] XO_ADDZE = 9'h0ca;
    localparam logic [9:0] XO_AND = 10'h01c;
    // Constants of the arithmetic
    localparam logic [31:0] ALL_ONES = 32'hffffffff;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [31:0] LINK_STEP = 32'h00000004;
    localparam logic [4:0] FIELD_ZERO = 5'h00;
    // Register map, byte addresses
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_COND = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic RST_ENABLE = 1'h1;
    // Instruction layouts, most significant field first
    typedef struct packed {
        logic [5:0] opcd; logic [4:0] rt; logic [4:0] ra; logic [4:0] rb;
        logic oe; logic [8:0] xo; logic rc;
    } iab_xo_s;
    typedef struct packed {
        logic [5:0] opcd; logic [4:0] rt; logic [4:0] ra; logic [15:0] imm;
    } iab_d_s;
    typedef struct packed {
        logic [5:0] opcd; logic [23:0] li; logic aa; logic lk;
    } iab_i_s;
    typedef struct packed { logic so; logic ov; logic ca; } iab_xer_s;
    typedef struct packed { logic lt; logic gt; logic eq; logic so; } iab_cr_s;
    typedef enum logic [13:0] {
        OP_ILLEGAL = 14'h0001, OP_ADD = 14'h0002, OP_ADDC = 14'h0004,
        OP_ADDE = 14'h0008, OP_ADDME = 14'h0010, OP_ADDZE = 14'h0020,
        OP_ADDI = 14'h0040, OP_ADDIS = 14'h0080, OP_ADDIC = 14'h0100,
        OP_ADDIC_REC = 14'h0200, OP_AND = 14'h0400, OP_ANDI = 14'h0800,
        OP_ANDIS = 14'h1000, OP_BRANCH = 14'h2000
    } iab_op_e;
    // Operands handed over by the decode stage
    typedef struct packed {
        logic [31:0] insn; logic [31:0] current_fetch_address;
        logic [31:0] val_a; logic [31:0] val_b; logic [31:0] val_s;
    } iab_issue_s;
    // Writes back to the register file and fetch unit
    typedef struct packed {
        logic wr_en; logic [4:0] wr_idx; logic [31:0] wr_data;
        logic link_en; logic [31:0] link_data;
        logic jump_en; logic [31:0] jump_addr;
        logic illegal;
    } iab_result_s;
endpackage : iab_pkg

// ### rtl/iab_exec.sv
// Integer add, logic and branch execution datapath with AXI4-Lite flag registers
// Summary of operation
// - Plain add writes the 32-bit sum of A and B into the target.
// - Record flag updates condition field zero; overflow enable updates sticky and signed flags.
// - Carrying add writes A plus B and sets carry when sum exceeds 32 bits.
// - Every carrying add takes its carry from bit 32 of the full sum.
// - Extended add writes A plus B plus carry, then updates carry.
// - Add immediate uses zero for A when its field is zero; carry untouched.
// - Add immediate carrying always reads A and updates carry.
// - Immediate carrying record and both AND-immediates always update condition field zero.
// - Add immediate shifted puts the literal in the upper half, lower half zero.
// - Minus-one extended add writes A plus carry plus all-ones; updates carry.
// - Zero extended add writes A plus carry; updates carry.
// - Register AND writes S and B into register A; record optional.
// - AND immediate zero-extends the literal, ANDs with S into A.
// - AND immediate shifted puts literal in upper half, ANDs with S into A.
// - Branch target is sign-widened offset times four, relative unless absolute flag set.
// - Save-return flag writes current address plus four into the return link.
// - Unknown opcode raises illegal; nonzero reserved bits still execute.
`timescale 1ns/10ps
`default_nettype none
module iab_exec (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Issue from decode stage
    input wire logic issue_valid_in,
    output logic issue_ready_out,
    input wire iab_pkg::iab_issue_s issue_in,
    // Results to register file and fetch
    output iab_pkg::iab_result_s res_out,
    output iab_pkg::iab_xer_s xer_out,
    output iab_pkg::iab_cr_s cr0_out,
    // AXI4-Lite slave
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [7:0] awaddr_in,
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    input wire logic arvalid_in,
    output logic arready_out,
    input wire logic [7:0] araddr_in,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out
);
    import iab_pkg::*;

    typedef struct packed {
        iab_xer_s exception_flags_register;
        iab_cr_s cr0;
        logic enable;
        logic [31:0] count;
        iab_result_s res;
        logic aw_got;
        logic w_got;
        logic [7:0] wr_addr;
        logic [31:0] wr_data;
        logic [3:0] wr_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } iab_state_s;

    iab_state_s st;
    iab_state_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] widen16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : widen16

    function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b, input logic cin);
        return {1'b0, a} + {1'b0, b} + {32'h00000000, cin};
    endfunction : add33

    function automatic logic wrap_signed(input logic [31:0] a, input logic [31:0] b, input logic [31:0] s);
        return (a[31] == b[31]) && (s[31] != a[31]);
    endfunction : wrap_signed

    function automatic iab_op_e decode(input logic [31:0] insn);
        iab_xo_s x;
        x = iab_xo_s'(insn);
        decode = OP_ILLEGAL;
        if (x.opcd == OPC_ADDI) begin
            decode = OP_ADDI;
        end else if (x.opcd == OPC_ADDIS) begin
            decode = OP_ADDIS;
        end else if (x.opcd == OPC_ADDIC) begin
            decode = OP_ADDIC;
        end else if (x.opcd == OPC_ADDIC_REC) begin
            decode = OP_ADDIC_REC;
        end else if (x.opcd == OPC_ANDI) begin
            decode = OP_ANDI;
        end else if (x.opcd == OPC_ANDIS) begin
            decode = OP_ANDIS;
        end else if (x.opcd == OPC_BRANCH) begin
            decode = OP_BRANCH;
        end else if (x.opcd == OPC_EXT) begin
            // Reserved bits of the zero-operand forms are not checked
            if ({x.oe, x.xo} == XO_AND) decode = OP_AND;
            else if (x.xo == XO_ADD) decode = OP_ADD;
            else if (x.xo == XO_ADDC) decode = OP_ADDC;
            else if (x.xo == XO_ADDE) decode = OP_ADDE;
            else if (x.xo == XO_ADDME) decode = OP_ADDME;
            else if (x.xo == XO_ADDZE) decode = OP_ADDZE;
        end
    endfunction : decode

    logic fire;
    iab_op_e op;
    iab_xo_s fx;
    iab_d_s fd;
    iab_i_s fi;

    assign fire = issue_valid_in && issue_ready_out;
    assign op = decode(issue_in.insn);
    assign fx = iab_xo_s'(issue_in.insn);
    assign fd = iab_d_s'(issue_in.insn);
    assign fi = iab_i_s'(issue_in.insn);

    assign issue_ready_out = st.enable;
    assign res_out = st.res;
    assign xer_out = st.exception_flags_register;
    assign cr0_out = st.cr0;
    assign awready_out = !st.aw_got && !st.bvalid;
    assign wready_out = !st.w_got && !st.bvalid;
    assign bvalid_out = st.bvalid;
    assign bresp_out = st.bresp;
    assign arready_out = !st.rvalid;
    assign rvalid_out = st.rvalid;
    assign rdata_out = st.rdata;
    assign rresp_out = st.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] base;
        logic [31:0] addend;
        logic cin;
        logic [32:0] sum;
        logic [31:0] result;
        logic rec;
        logic oe;
        logic upd_ca;
        logic is_add;
        logic [31:0] offset;
        base = issue_in.val_a;
        addend = issue_in.val_b;
        cin = 1'b0;
        sum = 33'h000000000;
        result = WORD_ZERO;
        rec = 1'b0;
        oe = 1'b0;
        upd_ca = 1'b0;
        is_add = 1'b1;
        offset = WORD_ZERO;
        next_st = st;
        next_st.res.wr_en = 1'b0;
        next_st.res.link_en = 1'b0;
        next_st.res.jump_en = 1'b0;
        next_st.res.illegal = 1'b0;

        // Register bus, write side
        if (awvalid_in && awready_out) begin
            next_st.aw_got = 1'b1;
            next_st.wr_addr = awaddr_in;
        end
        if (wvalid_in && wready_out) begin
            next_st.w_got = 1'b1;
            next_st.wr_data = wdata_in;
            next_st.wr_strb = wstrb_in;
        end
        if (st.bvalid && bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (st.wr_addr == REG_FLAGS) begin
                if (st.wr_strb[0]) next_st.exception_flags_register = iab_xer_s'(st.wr_data[2:0]);
            end else if (st.wr_addr == REG_COND) begin
                if (st.wr_strb[0]) next_st.cr0 = iab_cr_s'(st.wr_data[3:0]);
            end else if (st.wr_addr == REG_CTRL) begin
                if (st.wr_strb[0]) next_st.enable = st.wr_data[0];
            end else if (st.wr_addr != REG_COUNT) begin
                next_st.bresp = RESP_SLVERR;
            end
        end

        // Register bus, read side
        if (arvalid_in && arready_out) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = WORD_ZERO;
            if (araddr_in == REG_FLAGS) begin
                next_st.rdata[2:0] = st.exception_flags_register;
            end else if (araddr_in == REG_COND) begin
                next_st.rdata[3:0] = st.cr0;
            end else if (araddr_in == REG_CTRL) begin
                next_st.rdata[0] = st.enable;
            end else if (araddr_in == REG_COUNT) begin
                next_st.rdata = st.count;
            end else begin
                next_st.rresp = RESP_SLVERR;
            end
        end else if (st.rvalid && rready_in) begin
            next_st.rvalid = 1'b0;
        end

        // Execution; its flag updates override a bus write in the same cycle
        case (op)
            OP_ADD: begin rec = fx.rc; oe = fx.oe; end
            OP_ADDC: begin rec = fx.rc; oe = fx.oe; upd_ca = 1'b1; end
            OP_ADDE: begin rec = fx.rc; oe = fx.oe; upd_ca = 1'b1; cin = st.exception_flags_register.ca; end
            OP_ADDME: begin
                rec = fx.rc; oe = fx.oe; upd_ca = 1'b1; cin = st.exception_flags_register.ca; addend = ALL_ONES;
            end
            OP_ADDZE: begin
                rec = fx.rc; oe = fx.oe; upd_ca = 1'b1; cin = st.exception_flags_register.ca; addend = WORD_ZERO;
            end
            OP_ADDI: begin
                base = (fd.ra == FIELD_ZERO) ? WORD_ZERO : issue_in.val_a;
                addend = widen16(fd.imm);
            end
            OP_ADDIS: begin
                base = (fd.ra == FIELD_ZERO) ? WORD_ZERO : issue_in.val_a;
                addend = {fd.imm, HALF_ZERO};
            end
            OP_ADDIC: begin addend = widen16(fd.imm); upd_ca = 1'b1; end
            OP_ADDIC_REC: begin addend = widen16(fd.imm); upd_ca = 1'b1; rec = 1'b1; end
            OP_AND: begin
                is_add = 1'b0; rec = fx.rc; result = issue_in.val_s & issue_in.val_b;
            end
            OP_ANDI: begin
                is_add = 1'b0; rec = 1'b1; result = issue_in.val_s & {HALF_ZERO, fd.imm};
            end
            OP_ANDIS: begin
                is_add = 1'b0; rec = 1'b1; result = issue_in.val_s & {fd.imm, HALF_ZERO};
            end
            default: is_add = 1'b0;
        endcase
        sum = add33(base, addend, cin);
        if (is_add) result = sum[31:0];

        if (fire) begin
            next_st.count = st.count + 32'h00000001;
            if (op == OP_BRANCH) begin
                offset = {{6{fi.li[23]}}, fi.li, 2'b00};
                next_st.res.jump_en = 1'b1;
                next_st.res.jump_addr = fi.aa ? offset : issue_in.current_fetch_address + offset;
                next_st.res.link_en = fi.lk;
                next_st.res.link_data = issue_in.current_fetch_address + LINK_STEP;
            end else if (op == OP_ILLEGAL) begin
                next_st.res.illegal = 1'b1;
            end else begin
                next_st.res.wr_en = 1'b1;
                next_st.res.wr_idx = (op == OP_AND || op == OP_ANDI || op == OP_ANDIS) ? fd.ra : fd.rt;
                next_st.res.wr_data = result;
                if (upd_ca) next_st.exception_flags_register.ca = sum[32];
                if (oe) begin
                    next_st.exception_flags_register.ov = wrap_signed(base, addend, sum[31:0]);
                    next_st.exception_flags_register.so = st.exception_flags_register.so | next_st.exception_flags_register.ov;
                end
                if (rec) begin
                    next_st.cr0.lt = result[31];
                    next_st.cr0.gt = !result[31] && (result != WORD_ZERO);
                    next_st.cr0.eq = (result == WORD_ZERO);
                    next_st.cr0.so = next_st.exception_flags_register.so;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
            st.enable <= RST_ENABLE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_ADD_SUM: assert property (fire && op == OP_ADD |=>
        res_out.wr_en && res_out.wr_data == $past(issue_in.val_a) + $past(issue_in.val_b))
        else $error("add result wrong");
    AST_ADDC_CARRY: assert property (fire && op == OP_ADDC |=>
        xer_out.ca == ({1'b0, $past(issue_in.val_a)} + {1'b0, $past(issue_in.val_b)} > {1'b0, ALL_ONES}))
        else $error("carry of carrying add wrong");
    AST_ADDE_SUM: assert property (fire && op == OP_ADDE |=>
        res_out.wr_data == $past(issue_in.val_a) + $past(issue_in.val_b) + {31'h0, $past(xer_out.ca)})
        else $error("extended add result wrong");
    AST_ADDI_ZERO: assert property (fire && op == OP_ADDI && fd.ra == FIELD_ZERO |=>
        res_out.wr_data == widen16($past(fd.imm)) && xer_out.ca == $past(xer_out.ca))
        else $error("add immediate with zero field wrong");
    AST_ADDIS_HIGH: assert property (fire && op == OP_ADDIS && fd.ra != FIELD_ZERO |=>
        res_out.wr_data == $past(issue_in.val_a) + {$past(fd.imm), HALF_ZERO})
        else $error("add immediate shifted wrong");
    AST_ANDI_RESULT: assert property (fire && op == OP_ANDI |=>
        res_out.wr_idx == $past(fd.ra) && cr0_out.eq == (res_out.wr_data == WORD_ZERO)
        && res_out.wr_data == ($past(issue_in.val_s) & {HALF_ZERO, $past(fd.imm)}))
        else $error("and immediate wrong");
    AST_BRANCH_REL: assert property (fire && op == OP_BRANCH && !fi.aa |=>
        res_out.jump_en && res_out.jump_addr == $past(issue_in.current_fetch_address) + {{6{$past(fi.li[23])}}, $past(fi.li), 2'b00})
        else $error("relative branch target wrong");
    AST_LINK: assert property (fire && op == OP_BRANCH && fi.lk |=>
        res_out.link_en && res_out.link_data == $past(issue_in.current_fetch_address) + LINK_STEP && !res_out.wr_en)
        else $error("return link wrong");
    AST_ILLEGAL: assert property (fire && op == OP_ILLEGAL |=> res_out.illegal && !res_out.wr_en
        ##1 !res_out.illegal || $past(fire))
        else $error("illegal instruction not flagged");
    AST_NO_RECORD: assert property (fire && op == OP_ADD && !fx.rc && !fx.oe
        && !(st.aw_got && st.w_got && !st.bvalid) |=> $stable(cr0_out) && $stable(xer_out))
        else $error("flags changed without record or overflow enable");
    AST_OV_STICKY: assert property (fire && op == OP_ADD && fx.oe |=>
        xer_out.ov |-> (xer_out.so && $past(issue_in.val_a[31]) == $past(issue_in.val_b[31])))
        else $error("signed wrap without sticky");

    COV_ADDE_CHAIN: cover property (fire && op == OP_ADDC ##1 fire && op == OP_ADDE);
    COV_BRANCH_LINK: cover property (fire && op == OP_BRANCH && fi.lk && fi.aa);
    COV_OVERFLOW: cover property (fire && op == OP_ADD && fx.oe ##1 xer_out.ov);
    COV_REG_READ: cover property (rvalid_out && rready_in && rresp_out == RESP_OKAY);
endmodule : iab_exec
`default_nettype wire

// ### verification/iab_decode_model.sv
// Decode stage and register file model that feeds the execution block
`timescale 1ns/10ps
`default_nettype none
module iab_decode_model
    import iab_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Issue handshake
    input wire logic issue_ready_in,
    output logic issue_valid_out,
    output iab_pkg::iab_issue_s issue_out,
    // Write-back from the block
    input wire iab_pkg::iab_result_s res_in
);
    logic [31:0] gpr [32];
    int sent;

    initial begin
        issue_valid_out = 1'b0;
        issue_out = '0;
        sent = 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file takes each pulsed write-back
    always @(posedge clk_in) begin
        if (res_in.wr_en === 1'b1) begin
            gpr[res_in.wr_idx] <= res_in.wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offer held until the edge that samples ready high
    task automatic send(input logic [31:0] insn, input logic [31:0] current_fetch_address);
        issue_valid_out <= 1'b1;
        issue_out <= iab_issue_s'{insn, current_fetch_address, gpr[insn[20:16]], gpr[insn[15:11]], gpr[insn[25:21]]};
        do begin
            @(posedge clk_in);
        end while (issue_ready_in !== 1'b1);
        sent++;
    endtask : send

    // Released operands scramble so stale values never look valid
    task automatic idle();
        issue_valid_out <= 1'b0;
        issue_out <= ~issue_out;
    endtask : idle

    // Offer for a fixed span whatever ready says
    task automatic poke(input logic [31:0] insn, input int n);
        issue_valid_out <= 1'b1;
        issue_out.insn <= insn;
        repeat (n) @(posedge clk_in);
        issue_valid_out <= 1'b0;
    endtask : poke
endmodule : iab_decode_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench of the execution block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb;
    import iab_pkg::*;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic issue_valid, issue_ready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    iab_issue_s issue;
    iab_result_s res;
    iab_xer_s exception_flags_register;
    iab_cr_s cr0;
    int err_total = 0;
    int cmp_count = 0;

    iab_exec iab_exec_i (.clk_in(clk), .rst_in(rst), .issue_valid_in(issue_valid), .issue_ready_out(issue_ready),
        .issue_in(issue), .res_out(res), .xer_out(exception_flags_register), .cr0_out(cr0), .awvalid_in(awvalid),
        .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata),
        .wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid),
        .arready_out(arready), .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready),
        .rdata_out(rdata), .rresp_out(rresp));
    iab_decode_model iab_decode_model_i (.clk_in(clk), .issue_ready_in(issue_ready),
        .issue_valid_out(issue_valid), .issue_out(issue), .res_in(res));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] fx(logic [4:0] t, logic [4:0] a, logic [4:0] b, logic oe, logic [8:0] x,
        logic rc);
        return {OPC_EXT, t, a, b, oe, x, rc};
    endfunction : fx

    function automatic logic [31:0] fd(logic [5:0] o, logic [4:0] t, logic [4:0] a, logic [15:0] m);
        return {o, t, a, m};
    endfunction : fd

    ////////////////////////////////////////////////////////////////////////////
    task automatic op(input logic [31:0] insn, input logic [31:0] current_fetch_address);
        @(posedge clk);
        iab_decode_model_i.send(insn, current_fetch_address);
        iab_decode_model_i.idle();
        #1;
    endtask : op

    task automatic ckw(input logic [4:0] i, input logic [31:0] d, input logic [2:0] x);
        `CHK(res.wr_en, 1'b1)
        `CHK(res.wr_idx, i)
        `CHK(res.wr_data, d)
        `CHK(exception_flags_register, x)
    endtask : ckw

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) begin
                awvalid <= 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        `CHK(bresp, er)
        bready <= 1'b0;
        #1;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        `CHK(rdata, ed)
        `CHK(rresp, er)
        rready <= 1'b0;
    endtask : axi_rd

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_carry();
        op(fx(20, 3, 1, 0, XO_ADDC, 0), 0);
        ckw(20, 32'h0, 3'h1);
        @(posedge clk);
        iab_decode_model_i.send(fx(20, 3, 1, 0, XO_ADDC, 0), 0);
        iab_decode_model_i.send(fx(21, 1, 2, 0, XO_ADDE, 0), 0);
        iab_decode_model_i.idle();
        #1;
        ckw(21, 32'h4, 3'h0);
        op(fx(22, 1, 0, 0, XO_ADDME, 0), 0);
        ckw(22, 32'h0, 3'h1);
        op(fx(23, 3, 5, 0, XO_ADDZE, 0), 0);
        ckw(23, 32'h0, 3'h1);
        op(fx(24, 4, 1, 1, XO_ADD, 1), 0);
        ckw(24, 32'h80000000, 3'h7);
        `CHK(cr0, 4'h9)
        op(fx(25, 1, 2, 1, XO_ADD, 0), 0);
        ckw(25, 32'h3, 3'h5);
        `CHK(cr0, 4'h9)
        op(fx(25, 3, 3, 0, XO_ADD, 0), 0);
        ckw(25, 32'hfffffffe, 3'h5);
        `CHK(cr0, 4'h9)
    endtask : t_carry

    task automatic t_imm();
        op(fd(OPC_ADDI, 26, 0, 16'h8000), 0);
        ckw(26, 32'hffff8000, 3'h5);
        op(fd(OPC_ADDI, 26, 1, 16'hffff), 0);
        ckw(26, 32'h0, 3'h5);
        op(fd(OPC_ADDIS, 27, 0, 16'h1234), 0);
        ckw(27, 32'h12340000, 3'h5);
        op(fd(OPC_ADDIS, 27, 1, 16'h1234), 0);
        ckw(27, 32'h12340001, 3'h5);
        op(fd(OPC_ADDIC, 28, 0, 16'h0001), 0);
        ckw(28, 32'h6, 3'h4);
        op(fd(OPC_ADDIC_REC, 28, 1, 16'hffff), 0);
        ckw(28, 32'h0, 3'h5);
        `CHK(cr0, 4'h3)
    endtask : t_imm

    task automatic t_and();
        op(fx(5, 27, 6, XO_AND[9], XO_AND[8:0], 0), 0);
        ckw(27, 32'hf000f000, 3'h5);
        `CHK(cr0, 4'h3)
        op(fx(5, 27, 6, XO_AND[9], XO_AND[8:0], 1), 0);
        ckw(27, 32'hf000f000, 3'h5);
        `CHK(cr0, 4'h9)
        op(fd(OPC_ANDI, 5, 28, 16'hffff), 0);
        ckw(28, 32'h0000f0f0, 3'h5);
        `CHK(cr0, 4'h5)
        op(fd(OPC_ANDIS, 5, 29, 16'h8000), 0);
        ckw(29, 32'h80000000, 3'h5);
        `CHK(cr0, 4'h9)
    endtask : t_and

    task automatic t_branch();
        op({OPC_BRANCH, 24'hfffffe, 1'b0, 1'b1}, 32'h1000);
        `CHK({res.wr_en, res.jump_en, res.jump_addr}, {2'b01, 32'h00000ff8})
        `CHK({res.link_en, res.link_data}, {1'b1, 32'h1004})
        op({OPC_BRANCH, 24'h000040, 1'b1, 1'b0}, 32'h1000);
        `CHK({res.jump_en, res.jump_addr, res.link_en}, {1'b1, 32'h100, 1'b0})
        op(32'h0, 32'h2000);
        `CHK({res.illegal, res.wr_en, res.jump_en}, 3'b100)
    endtask : t_branch

    task automatic t_bus();
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        axi_rd(REG_FLAGS, 32'h5, RESP_OKAY);
        axi_rd(REG_COND, 32'h9, RESP_OKAY);
        axi_rd(REG_COUNT, iab_decode_model_i.sent, RESP_OKAY);
        axi_wr(REG_FLAGS, 32'h0, RESP_OKAY);
        `CHK(exception_flags_register, 3'h0)
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        axi_wr(8'h10, 32'h1, RESP_SLVERR);
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        `CHK(issue_ready, 1'b0)
        iab_decode_model_i.poke(fx(20, 1, 2, 0, XO_ADD, 0), 4);
        `CHK(res.wr_en, 1'b0)
        axi_rd(REG_COUNT, iab_decode_model_i.sent, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        `CHK(issue_ready, 1'b1)
    endtask : t_bus

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        iab_decode_model_i.gpr = '{0: 32'h5, 1: 32'h1, 2: 32'h2, 3: 32'hffffffff, 4: 32'h7fffffff,
            5: 32'hf0f0f0f0, 6: 32'hff00ff00, default: 32'h0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_carry();
        t_imm();
        t_and();
        t_branch();
        t_bus();
        complete_run();
    end
endmodule : tb
`default_nettype wire
